// ==== system_clock_select_failover.sv ====
// clock source select, unlock guard and clock failure detection
`timescale 1ns/1ps
// What this block does
// - control writes need E7 then 18 first
// - out-of-order control writes leave register unchanged
// - unlock survives accesses to other registers
// - precision rc enabled at reset, never auto-cleared
// - primary failure raises event, forces watchdog clock
// - no switchover when watchdog selected or disabled
// - primary failure below about one kilohertz
// - watchdog failure raises event, keeps clock selection
// - watchdog failure disables primary failure detection
// - watchdog failure after 8004 clocks without edge
// - all sources off halts until power-on reset
// - failover only when watchdog oscillator enabled
// - select field decodes five sources, rest reserved
// - control register bit layout and reset values
module system_clock_select_failover
  import osc_ctrl_pkg::*;
#(
  parameter int WD_FAIL_CYCLES = WD_FAIL_SYSCLKS
) (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // raw oscillator activity, asynchronous to hclk
  input  wire logic        wd_osc_clk,
  input  wire logic        selected_osc_clk,
  // oscillator controls
  output logic             precision_rc_enable,
  output logic             crystal_enable,
  output logic             wd_osc_enable,
  output logic      [2:0]  clock_source_select,
  // failure events and halt
  output logic             primary_fail_event,
  output logic             wd_fail_event,
  output logic             device_halted
);

  // count at which the failure fires; the counter parks there until cleared
  localparam logic [13:0] WD_LIMIT = 14'(WD_FAIL_CYCLES - 1);

  lock_state_t lock_r;            // unlock sequence state
  logic [7:0]  ctrl_r;            // oscillator control register
  logic [1:0]  flags_r;           // sticky failure flags
  logic        wd_dead_r;         // watchdog oscillator has failed
  logic        halted_r;          // device stopped, needs power-on
  logic        wr_pend_r;         // data phase of a write
  logic        wr_ctrl_r;         // pending write hits control
  logic        wr_stat_r;         // pending write hits status
  logic [2:0]  wd_sync_r;         // watchdog pin synchroniser + edge
  logic [2:0]  sel_sync_r;        // selected clock synchroniser + edge
  logic [3:0]  prim_cnt_r;        // watchdog edges since primary edge
  logic        prim_lost_r;       // primary failure already reported
  logic [13:0] wd_cnt_r;          // hclk cycles since watchdog edge
  logic [7:0]  wdata;             // write byte in data phase
  logic        ctrl_wr;           // control write this cycle
  logic        stat_wr;           // status write this cycle
  logic        addr_ok;           // valid address phase
  logic        wd_edge;           // watchdog oscillator edge seen
  logic        sel_edge;          // selected clock edge seen
  logic        prim_det_on;       // primary detector running
  logic        wd_det_on;         // watchdog detector running
  logic        prim_fail;         // primary failure this cycle
  logic        wd_fail;           // watchdog failure this cycle
  logic        failover_go;       // force watchdog clock now
  logic        sel_dead;          // selected source is not running
  logic [2:0]  sel;               // current select field

  assign sel       = ctrl_r[SEL_MSB:0];
  assign wdata     = hwdata[7:0];
  assign ctrl_wr   = wr_pend_r && wr_ctrl_r;
  assign stat_wr   = wr_pend_r && wr_stat_r;
  assign addr_ok   = hsel && hready && (htrans == HTRANS_NONSEQ)
                     && (hsize == HSIZE_WORD);
  assign hreadyout = 1'b1;        // zero wait states
  assign hresp     = 1'b0;        // always okay

  // latch address phase so the write lands in its data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_ctrl_r <= 1'b0;
      wr_stat_r <= 1'b0;
    end else if (hready) begin
      wr_pend_r <= addr_ok && hwrite;
      wr_ctrl_r <= haddr == CTRL_ADDR;
      wr_stat_r <= haddr == STAT_ADDR;
    end
  end

  // read data sampled at the address phase; unmapped reads give zero
  // limitation: a read right behind a control write sees the old value,
  // since that write lands on the same edge that samples the read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_ok && !hwrite) begin
      if (haddr == CTRL_ADDR) begin
        hrdata <= {24'h00_0000, ctrl_r};
      end else if (haddr == STAT_ADDR) begin
        hrdata <= {26'h000_0000, lock_r, halted_r, wd_dead_r, flags_r};
      end else begin
        hrdata <= 32'h0000_0000;
      end
    end
  end

  // unlock sequence; only control writes move it, reset locks it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lock_r <= LOCKED;
    end else if (ctrl_wr) begin
      case (lock_r)
        LOCKED: begin
          if (wdata == UNLOCK_FIRST) begin
            lock_r <= GOT_FIRST;
          end
        end
        GOT_FIRST: begin
          if (wdata == UNLOCK_SECOND) begin
            lock_r <= UNLOCKED;
          end else if (wdata == UNLOCK_FIRST) begin
            lock_r <= GOT_FIRST;                      // restart sequence
          end else begin
            lock_r <= LOCKED;
          end
        end
        UNLOCKED: lock_r <= LOCKED;
        default:  lock_r <= LOCKED;
      endcase
    end
  end

  // control register: software write when unlocked, failover override
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= CTRL_RESET;
    end else begin
      if (ctrl_wr && lock_r == UNLOCKED) begin
        ctrl_r <= wdata;
      end
      // hardware only ever touches the select field, never enables
      if (failover_go) begin
        ctrl_r[SEL_MSB:0] <= SEL_WD_OSC;
      end
    end
  end

  // pin synchronisers; first stage feeds only the second
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wd_sync_r  <= 3'h0;
      sel_sync_r <= 3'h0;
    end else begin
      wd_sync_r  <= {wd_sync_r[1:0], wd_osc_clk};
      sel_sync_r <= {sel_sync_r[1:0], selected_osc_clk};
    end
  end
  assign wd_edge  = wd_sync_r[1] && !wd_sync_r[2];
  assign sel_edge = sel_sync_r[1] && !sel_sync_r[2];

  // primary detector is timed by the watchdog oscillator
  assign prim_det_on = ctrl_r[BIT_PRIM_DET_EN] && ctrl_r[BIT_WD_OSC_EN]
                       && !wd_dead_r;
  assign prim_fail   = prim_det_on && !prim_lost_r
                       && (prim_cnt_r == PRIM_FAIL_TICKS);
  // substitution only with a live, unselected watchdog oscillator
  assign failover_go = prim_fail && ctrl_r[BIT_WD_OSC_EN]
                       && (sel != SEL_WD_OSC);

  // count watchdog edges with no primary edge: ten means under 1 khz
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prim_cnt_r  <= 4'h0;
      prim_lost_r <= 1'b0;
    end else if (!prim_det_on || sel_edge) begin
      prim_cnt_r  <= 4'h0;
      prim_lost_r <= 1'b0;
    end else begin
      if (wd_edge && prim_cnt_r != PRIM_FAIL_TICKS) begin
        prim_cnt_r <= prim_cnt_r + 4'h1;
      end
      if (prim_fail) begin
        prim_lost_r <= 1'b1;                          // report once
      end
    end
  end

  // watchdog detector counts hclk cycles between watchdog edges
  assign wd_det_on = ctrl_r[BIT_WD_DET_EN] && !wd_dead_r;
  assign wd_fail   = wd_det_on && (wd_cnt_r == WD_LIMIT);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wd_cnt_r <= 14'h0000;
    end else if (!wd_det_on || wd_edge) begin
      wd_cnt_r <= 14'h0000;
    end else if (wd_cnt_r != WD_LIMIT) begin
      wd_cnt_r <= wd_cnt_r + 14'h0001;
    end
  end

  // watchdog failure is permanent until reset; it changes no select
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wd_dead_r <= 1'b0;
    end else if (wd_fail) begin
      wd_dead_r <= 1'b1;
    end
  end

  // sticky flags, write one to clear; a new event beats the clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags_r <= 2'h0;
    end else begin
      if (stat_wr) begin
        flags_r <= flags_r & ~wdata[1:0];
      end
      if (prim_fail) begin
        flags_r[BIT_PRIM_FAIL] <= 1'b1;
      end
      if (wd_fail) begin
        flags_r[BIT_WD_FAIL] <= 1'b1;
      end
    end
  end

  // event pulses toward the non-maskable interrupt logic
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      primary_fail_event <= 1'b0;
      wd_fail_event      <= 1'b0;
    end else begin
      primary_fail_event <= prim_fail;
      wd_fail_event      <= wd_fail;
    end
  end

  // is the chosen source switched off or reserved
  always_comb begin
    case (sel)
      SEL_RC_FAST: sel_dead = !ctrl_r[BIT_RC_EN];
      SEL_RC_SLOW: sel_dead = !ctrl_r[BIT_RC_EN];
      SEL_XTAL:    sel_dead = !ctrl_r[BIT_XTAL_EN];
      SEL_WD_OSC:  sel_dead = !ctrl_r[BIT_WD_OSC_EN];
      SEL_EXT_PIN: sel_dead = 1'b0;   // pin driven from outside
      default:     sel_dead = 1'b1;   // reserved codes run nothing
    endcase
  end

  // dead source with no recovery path stops the chip until reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      halted_r <= 1'b0;
    end else if (sel_dead && !prim_det_on) begin
      halted_r <= 1'b1;
    end
  end

  // outputs straight from the control and halt flip-flops
  assign precision_rc_enable = ctrl_r[BIT_RC_EN];
  assign crystal_enable      = ctrl_r[BIT_XTAL_EN];
  assign wd_osc_enable       = ctrl_r[BIT_WD_OSC_EN];
  assign clock_source_select = sel;
  assign device_halted       = halted_r;

  // checks
  AST_UNLOCKED_WRITE: assert property (@(posedge hclk) disable iff
    (!hresetn) (ctrl_wr && lock_r == UNLOCKED && !failover_go)
    |=> (ctrl_r == $past(wdata)) && (lock_r == LOCKED))
    else $error("unlocked control write not applied");
  AST_LOCKED_IGNORE: assert property (@(posedge hclk) disable iff
    (!hresetn) (!(ctrl_wr && lock_r == UNLOCKED) && !failover_go)
    |=> $stable(ctrl_r))
    else $error("control changed without unlock");
  AST_OTHER_ACCESS: assert property (@(posedge hclk) disable iff
    (!hresetn) (!ctrl_wr) |=> $stable(lock_r))
    else $error("unlock state moved by other access");
  AST_RC_KEPT: assert property (@(posedge hclk) disable iff
    (!hresetn) (!(ctrl_wr && lock_r == UNLOCKED))
    |=> !$fell(ctrl_r[BIT_RC_EN]))
    else $error("precision rc enable cleared by hardware");
  AST_FAILOVER: assert property (@(posedge hclk) disable iff
    (!hresetn) (prim_fail && ctrl_r[BIT_WD_OSC_EN])
    |=> (sel == SEL_WD_OSC) && primary_fail_event
    ##1 !primary_fail_event)
    else $error("primary failure did not force watchdog clock");
  AST_NO_FAILOVER: assert property (@(posedge hclk) disable iff
    (!hresetn) (!ctrl_r[BIT_WD_OSC_EN] && !ctrl_wr)
    |=> $stable(sel))
    else $error("switchover with watchdog oscillator off");
  AST_PRIM_TICKS: assert property (@(posedge hclk) disable iff
    (!hresetn) prim_fail |-> (prim_cnt_r == PRIM_FAIL_TICKS)
    ##1 primary_fail_event)
    else $error("primary failure at wrong tick count");
  AST_WD_COUNT: assert property (@(posedge hclk) disable iff
    (!hresetn) $rose(wd_dead_r) |-> $past(wd_cnt_r) == WD_LIMIT
    && wd_fail_event)
    else $error("watchdog failure at wrong cycle count");
  AST_WD_NOSWITCH: assert property (@(posedge hclk) disable iff
    (!hresetn) (wd_fail && !prim_fail && !ctrl_wr)
    |=> $stable(sel))
    else $error("watchdog failure changed clock select");
  AST_PRIM_DEAD: assert property (@(posedge hclk) disable iff
    (!hresetn) wd_dead_r |-> !prim_fail)
    else $error("primary detection after watchdog failure");
  AST_HALT_STICKY: assert property (@(posedge hclk) disable iff
    (!hresetn) halted_r |=> halted_r [*2])
    else $error("halt released without reset");

  COV_UNLOCK_WRITE: cover property (@(posedge hclk) disable iff
    (!hresetn) ctrl_wr && lock_r == UNLOCKED);
  COV_FAILOVER: cover property (@(posedge hclk) disable iff
    (!hresetn) failover_go);
  COV_WD_FAIL: cover property (@(posedge hclk) disable iff
    (!hresetn) wd_fail);
  COV_HALT: cover property (@(posedge hclk) disable iff
    (!hresetn) $rose(halted_r));
  COV_SPLIT_UNLOCK: cover property (@(posedge hclk) disable iff
    (!hresetn) lock_r == GOT_FIRST && wr_pend_r && !wr_ctrl_r);

endmodule

// ==== osc_ctrl_pkg.sv ====
// constants for the system clock select and failover block
package osc_ctrl_pkg;
  // register indices; byte address is four times the index
  localparam logic [11:0] CTRL_INDEX = 12'hF86;
  localparam logic [11:0] STAT_INDEX = 12'hF87;
  localparam logic [31:0] CTRL_ADDR  = {18'h0_0000, CTRL_INDEX, 2'b00};
  localparam logic [31:0] STAT_ADDR  = {18'h0_0000, STAT_INDEX, 2'b00};

  // unlock values
  localparam logic [7:0] UNLOCK_FIRST  = 8'hE7;
  localparam logic [7:0] UNLOCK_SECOND = 8'h18;

  // control register layout and reset value
  localparam logic [7:0] CTRL_RESET      = 8'hA0;
  localparam int         BIT_RC_EN       = 7;
  localparam int         BIT_XTAL_EN     = 6;
  localparam int         BIT_WD_OSC_EN   = 5;
  localparam int         BIT_PRIM_DET_EN = 4;
  localparam int         BIT_WD_DET_EN   = 3;
  localparam int         SEL_MSB         = 2;

  // status register layout
  localparam int BIT_PRIM_FAIL = 0;
  localparam int BIT_WD_FAIL   = 1;
  localparam int BIT_WD_DEAD   = 2;
  localparam int BIT_HALTED    = 3;
  localparam int LOCK_LSB      = 4;

  // clock source select codes
  localparam logic [2:0] SEL_RC_FAST  = 3'h0;
  localparam logic [2:0] SEL_RC_SLOW  = 3'h1;
  localparam logic [2:0] SEL_XTAL     = 3'h2;
  localparam logic [2:0] SEL_WD_OSC   = 3'h3;
  localparam logic [2:0] SEL_EXT_PIN  = 3'h4;

  // failure thresholds
  localparam int FAIL_FREQ_HZ      = 1000;
  localparam int WD_OSC_HZ         = 10000;
  localparam int PRIM_FAIL_TICKS_I = WD_OSC_HZ / FAIL_FREQ_HZ;
  localparam logic [3:0] PRIM_FAIL_TICKS = PRIM_FAIL_TICKS_I[3:0];
  localparam int WD_FAIL_SYSCLKS   = 8004;

  // ahb-lite codes
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;

  // unlock sequence states
  typedef enum logic [1:0] {
    LOCKED,
    GOT_FIRST,
    UNLOCKED
  } lock_state_t;
endpackage

// ==== testbench.sv ====
// self-checking bench for the clock select and failover block
`timescale 1ns/1ps
module testbench
  import osc_ctrl_pkg::*;
;
  localparam int WDC = 40;               // shortened watchdog fail count
  localparam int XTAL_WAIT = 5000;       // crystal settle wait, rc cycles
  // clock and reset
  logic        hclk;
  logic        hresetn;
  // bus signals
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  wire  logic  hready;
  wire  logic [31:0] hrdata;
  wire  logic  hresp;
  // oscillator activity and outputs
  logic        wd_osc_clk;
  logic        selected_osc_clk;
  logic        wd_run;                   // watchdog oscillator toggling
  logic        sel_run;                  // selected oscillator toggling
  logic        tick;
  wire  logic  rc_en;
  wire  logic  xtal_en;
  wire  logic  wd_en;
  wire  logic [2:0] sel;
  wire  logic  prim_ev;
  wire  logic  wd_ev;
  wire  logic  halted;
  // model state and bookkeeping
  logic [7:0]  m_ctrl;
  int          m_lock;
  int          pcnt;
  int          wcnt;
  int          num_errors;
  int          check_count;
  int          seed;
  logic [31:0] rd;

  system_clock_select_failover #(.WD_FAIL_CYCLES(WDC)) i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
    .wd_osc_clk(wd_osc_clk), .selected_osc_clk(selected_osc_clk),
    .precision_rc_enable(rc_en), .crystal_enable(xtal_en),
    .wd_osc_enable(wd_en), .clock_source_select(sel),
    .primary_fail_event(prim_ev), .wd_fail_event(wd_ev),
    .device_halted(halted));

  // clock generator, 4 ns period
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  // oscillators toggle every other cycle while running
  always @(posedge hclk) begin
    tick <= ~tick;
    if (wd_run && tick) wd_osc_clk <= ~wd_osc_clk;
    if (sel_run && tick) selected_osc_clk <= ~selected_osc_clk;
  end

  // count one-cycle failure pulses
  always @(posedge hclk) begin
    if (prim_ev === 1'b1) pcnt <= pcnt + 1;
    if (wd_ev === 1'b1) wcnt <= wcnt + 1;
  end

  // hang guard, far beyond the expected run length
  initial begin
    #(20000 * 4);
    num_errors = num_errors + 1;
    tally_and_finish();
  end

  task automatic tally_and_finish();
    if (num_errors == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check_eq(input logic [31:0] exp, input logic [31:0] act);
    check_count = check_count + 1;
    if (act !== exp) begin
      num_errors = num_errors + 1;
      $display("Error at %0t: expected %h got %h", $time, exp, act);
    end
  endtask

  // one single word transfer; ends right after the data phase edge
  task automatic bus_xfer(input logic w, input logic [31:0] a,
                          input logic [7:0] d, output logic [31:0] r);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    hsize  <= HSIZE_WORD;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hsel   <= 1'b0;
    // upper bits random: only the low byte may matter
    hwdata <= {$random(seed)} & 32'hFFFF_FF00 | {24'h0, d};
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask

  // control write, mirrored in the unlock model
  task automatic ctrl_wr(input logic [7:0] d);
    bus_xfer(1'b1, CTRL_ADDR, d, rd);
    if (m_lock == 2) begin
      m_ctrl = d;
      m_lock = 0;
    end else if (d == UNLOCK_FIRST) m_lock = 1;
    else if (m_lock == 1 && d == UNLOCK_SECOND) m_lock = 2;
    else m_lock = 0;
  endtask

  task automatic unlock_wr(input logic [7:0] d);
    ctrl_wr(UNLOCK_FIRST);
    ctrl_wr(UNLOCK_SECOND);
    ctrl_wr(d);
  endtask

  // compare pins and register readback with the model
  task automatic check_ctrl();
    @(posedge hclk);
    check_eq({24'h0, m_ctrl & 8'hE7},
             {24'h0, rc_en, xtal_en, wd_en, 2'b00, sel});
    bus_xfer(1'b0, CTRL_ADDR, 8'h00, rd);
    check_eq({24'h0, m_ctrl}, rd);
    check_eq(32'h0, {31'h0, hresp});
  endtask

  task automatic do_reset(input int n);
    hresetn <= 1'b0;
    repeat (n) @(posedge hclk);
    hresetn <= 1'b1;
    m_ctrl = CTRL_RESET;
    m_lock = 0;
    @(posedge hclk);
  endtask

  initial begin
    hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0;
    hwrite = 1'b0; hsize = HSIZE_WORD; hwdata = 32'h0;
    wd_osc_clk = 1'b0; selected_osc_clk = 1'b0; tick = 1'b0;
    wd_run = 1'b1; sel_run = 1'b1; pcnt = 0; wcnt = 0;
    num_errors = 0; check_count = 0; seed = 32'h92ff_d871;
    do_reset(4);
    check_ctrl();
    // locked writes with random data are ignored
    repeat (4) begin
      logic [7:0] d;
      d = 8'($random(seed));
      if (d == UNLOCK_FIRST) d = d ^ 8'h01;
      ctrl_wr(d);
    end
    ctrl_wr(UNLOCK_SECOND); ctrl_wr(UNLOCK_FIRST); ctrl_wr(8'h55);
    check_ctrl();
    // unlock with other accesses between the two values
    ctrl_wr(UNLOCK_FIRST);
    bus_xfer(1'b0, STAT_ADDR, 8'h00, rd);
    check_eq(32'h0000_0010, rd & 32'h0000_0030);
    bus_xfer(1'b1, 32'h0000_0100, 8'hAA, rd);
    bus_xfer(1'b0, 32'h0000_0100, 8'h00, rd);
    check_eq(32'h0000_0000, rd);
    ctrl_wr(UNLOCK_SECOND); ctrl_wr(8'hE1);
    check_ctrl();
    ctrl_wr(8'hE2);
    check_ctrl();
    // every defined select code
    for (int c = 0; c < 5; c++) begin
      if (c == SEL_XTAL) repeat (XTAL_WAIT) @(posedge hclk);
      unlock_wr(8'hE0 | 8'(c));
      check_ctrl();
    end
    // primary failover to the watchdog oscillator
    unlock_wr(8'hA0);
    unlock_wr(8'hB0);
    sel_run = 1'b0;
    for (int i = 0; i < 300 && pcnt == 0; i++) @(posedge hclk);
    m_ctrl[2:0] = SEL_WD_OSC;
    check_eq(32'd1, pcnt);
    check_ctrl();
    repeat (100) @(posedge hclk);
    check_eq(32'd1, pcnt);
    check_ctrl();
    // no substitution with the watchdog oscillator disabled
    sel_run = 1'b1;
    unlock_wr(8'hA3);
    unlock_wr(8'h80);
    unlock_wr(8'h90);
    sel_run = 1'b0;
    repeat (100) @(posedge hclk);
    check_eq(32'd1, pcnt);
    check_ctrl();
    // watchdog oscillator failure keeps the selection
    sel_run = 1'b1;
    unlock_wr(8'hA8);
    wd_run = 1'b0;
    repeat (WDC - 4) @(posedge hclk);
    check_eq(32'd0, wcnt);
    for (int i = 0; i < 16 && wcnt == 0; i++) @(posedge hclk);
    check_eq(32'd1, wcnt);
    check_ctrl();
    // primary detection no longer works after that
    unlock_wr(8'hB0);
    sel_run = 1'b0;
    wd_run = 1'b1;
    repeat (100) @(posedge hclk);
    check_eq(32'd1, pcnt);
    check_ctrl();
    bus_xfer(1'b0, STAT_ADDR, 8'h00, rd);
    check_eq(32'h0000_0007, rd & 32'h0000_003F);
    bus_xfer(1'b1, STAT_ADDR, 8'h03, rd);
    bus_xfer(1'b0, STAT_ADDR, 8'h00, rd);
    check_eq(32'h0000_0004, rd & 32'h0000_003F);
    // everything off: device halts until reset
    sel_run = 1'b1;
    unlock_wr(8'hA0);
    unlock_wr(8'h05);
    repeat (20) @(posedge hclk);
    check_eq(32'd1, {31'h0, halted});
    // half an unlock before reset must not count afterwards
    ctrl_wr(UNLOCK_FIRST);
    do_reset(2);
    check_eq(32'd0, {31'h0, halted});
    ctrl_wr(UNLOCK_SECOND); ctrl_wr(8'h55);
    check_ctrl();
    tally_and_finish();
  end
endmodule
